// ---- hdl/i2cd_pkg.sv ----
package i2cd_pkg;

  // Slave address and command byte layout
  localparam logic [2:0] ADDR_FIXED_HI = 3'h3;
  localparam int         CMD_VALID_BIT = 7;
  localparam int         CMD_CLASS_BIT = 6;
  localparam int         CMD_OP_HI     = 5;
  localparam int         CMD_OP_LO     = 4;
  localparam int         CMD_RATE_HI   = 3;
  localparam int         CMD_RS_HI     = 5;
  localparam int         CMD_RS_LO     = 1;
  localparam int         CMD_DIR_BIT   = 0;

  localparam logic [1:0] OP_NONE  = 2'h0;
  localparam logic [1:0] OP_PDOWN = 2'h1;
  localparam logic [1:0] OP_CAL   = 2'h2;
  localparam logic [1:0] OP_SEQ   = 2'h3;

  localparam logic [1:0] PDS_ACTIVE  = 2'h0;
  localparam logic [1:0] PDS_SLEEP   = 2'h1;
  localparam logic [1:0] PDS_STANDBY = 2'h2;
  localparam logic [1:0] PDS_RESET   = PDS_SLEEP;

  typedef enum logic [1:0] {STRAP_GND, STRAP_VDD, STRAP_SDA} i2cd_strap_t;

  // Controller register map
  localparam logic [7:0] REG_CMD_OFF  = 8'h00;
  localparam logic [7:0] REG_STAT_OFF = 8'h04;
  localparam int         CMDF_START   = 8;
  localparam int         CMDF_STOP    = 9;
  localparam int         CMDF_READ    = 10;
  localparam int         CMDF_ACK     = 11;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_ACKRX   = 1;
  localparam int         STAT_RX_LO   = 8;
  localparam logic [31:0] CMD_RESET   = 32'h0;

  // Serial clock quarter period made by the controller
  localparam int         CLK_NS       = 10;
  localparam int         SCL_QTR_NS   = 50;
  localparam logic [3:0] SCL_QTR_CYC  = 4'((SCL_QTR_NS + CLK_NS - 1) / CLK_NS);

  // Two address bits contributed by one strap
  function automatic logic [1:0] i2cd_strap_bits(i2cd_strap_t s);
    unique case (s)
      STRAP_GND: return 2'h0;
      STRAP_VDD: return 2'h1;
      default:   return 2'h3;
    endcase
  endfunction

endpackage

// ---- hdl/i2cd_if.sv ----
`timescale 1ns/1ps
interface i2cd_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // Wired-AND open-drain bus with pull-ups
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);

  modport dev  (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface

// ---- hdl/i2cd_dev.sv ----
`timescale 1ns/1ps
module i2cd_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  i2cd_if.dev              bus,
  input  wire logic        addr_strap_low,
  input  wire logic        addr_strap_high,
  input  wire logic [1:0]  powerdown_target,
  input  wire logic [1:0]  calibration_kind,
  input  wire logic        single_cycle_select,
  input  wire logic        continuous_single_cycle_flag,
  input  wire logic        seq_done,
  input  wire logic [7:0]  reg_rdata,
  output logic             op_req,
  output logic [1:0]       op_code,
  output logic [3:0]       conv_rate,
  output logic [1:0]       cal_kind,
  output logic [4:0]       register_select,
  output logic             reg_wr,
  output logic [7:0]       reg_wdata,
  output logic [1:0]       powerdown_state_status
);
  typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_RACK} i2cd_dst_t;
  logic [2:0]            scl_s_q, sda_s_q;
  logic [1:0]            stl_s_q, sth_s_q, syn_ok_q, byte_q, byte_d;
  logic [1:0]            seen_lo_q, seen_lo_d, seen_hi_q, seen_hi_d, op_code_d, cal_kind_d, pds_d;
  i2cd_dst_t             st_q, st_d;
  logic [7:0]            sh_q, sh_d, wdata_d;
  logic [3:0]            bit_q, bit_d, conv_rate_d, addr_low;
  logic                  rd_xfer_q, rd_xfer_d, wr_ok_q, wr_ok_d, sda_oe_q, sda_oe_d;
  logic                  op_req_d, reg_wr_d;
  logic [4:0]            rs_d;
  logic                  scl_rise, scl_fall, start_c, stop_c, sda_stable;
  i2cd_pkg::i2cd_strap_t strap_lo, strap_hi;
  assign bus.sda_oe_dev = sda_oe_q;
  // Pins pass two flops; third stage for edges and the data stability check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_q  <= 3'h7;
      sda_s_q  <= 3'h7;
      stl_s_q  <= 2'h0;
      sth_s_q  <= 2'h0;
      syn_ok_q <= 2'h0;
    end else if (clk_en) begin
      scl_s_q  <= {scl_s_q[1:0], bus.scl};
      sda_s_q  <= {sda_s_q[1:0], bus.sda};
      stl_s_q  <= {stl_s_q[0], addr_strap_low};
      sth_s_q  <= {sth_s_q[0], addr_strap_high};
      syn_ok_q <= {syn_ok_q[0], 1'b1};
    end
  end
  assign scl_rise   = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall   = ~scl_s_q[1] & scl_s_q[2];
  assign start_c    = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  assign stop_c     = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];
  // Strap sync stages hold reset values at first
  assign sda_stable = syn_ok_q[1] && (sda_s_q[1] == sda_s_q[2]);
  // strap level against data line level
  always_comb begin
    seen_lo_d = seen_lo_q;
    seen_hi_d = seen_hi_q;
    if (sda_stable && sda_s_q[1]) begin
      seen_lo_d = seen_lo_q | ~{sth_s_q[1], stl_s_q[1]};
    end
    if (sda_stable && !sda_s_q[1]) begin
      seen_hi_d = seen_hi_q | {sth_s_q[1], stl_s_q[1]};
    end
  end
  assign strap_lo = seen_lo_q[0] ? i2cd_pkg::STRAP_GND :
                    (seen_hi_q[0] ? i2cd_pkg::STRAP_VDD : i2cd_pkg::STRAP_SDA);
  assign strap_hi = seen_lo_q[1] ? i2cd_pkg::STRAP_GND :
                    (seen_hi_q[1] ? i2cd_pkg::STRAP_VDD : i2cd_pkg::STRAP_SDA);
  assign addr_low = {i2cd_pkg::i2cd_strap_bits(strap_hi), i2cd_pkg::i2cd_strap_bits(strap_lo)};
  always_comb begin
    st_d        = st_q;
    sh_d        = sh_q;
    bit_d       = bit_q;
    byte_d      = byte_q;
    rd_xfer_d   = rd_xfer_q;
    wr_ok_d     = wr_ok_q;
    sda_oe_d    = sda_oe_q;
    op_req_d    = 1'b0;
    reg_wr_d    = 1'b0;
    op_code_d   = op_code;
    conv_rate_d = conv_rate;
    cal_kind_d  = cal_kind;
    rs_d        = register_select;
    wdata_d     = reg_wdata;
    pds_d       = powerdown_state_status;
    if (start_c) begin
      st_d     = D_RECV;
      bit_d    = 4'h0;
      byte_d   = 2'h0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      st_d     = D_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        D_IDLE: ;
        D_RECV: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s_q[1]};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            sda_oe_d = 1'b1;
            st_d     = D_ACK;
            if (byte_q == 2'h0) begin
              // seven-bit match, general call never matches
              if (sh_q[7:1] != {i2cd_pkg::ADDR_FIXED_HI, addr_low}) begin
                sda_oe_d = 1'b0;
                st_d     = D_IDLE;
              end
              rd_xfer_d = sh_q[0];
              byte_d    = 2'h1;
            end else if (byte_q == 2'h1) begin
              byte_d  = 2'h2;
              wr_ok_d = 1'b0;
              if (sh_q[i2cd_pkg::CMD_VALID_BIT]) begin
                if (!sh_q[i2cd_pkg::CMD_CLASS_BIT]) begin
                  op_code_d   = sh_q[i2cd_pkg::CMD_OP_HI:i2cd_pkg::CMD_OP_LO];
                  conv_rate_d = sh_q[i2cd_pkg::CMD_RATE_HI:0];
                  op_req_d    = op_code_d != i2cd_pkg::OP_NONE;
                  cal_kind_d  = calibration_kind;
                  unique case (op_code_d)
                    i2cd_pkg::OP_PDOWN: pds_d = powerdown_target;
                    i2cd_pkg::OP_SEQ, i2cd_pkg::OP_CAL: pds_d = i2cd_pkg::PDS_ACTIVE;
                    i2cd_pkg::OP_NONE:  pds_d = powerdown_state_status;
                  endcase
                end else begin
                  rs_d    = sh_q[i2cd_pkg::CMD_RS_HI:i2cd_pkg::CMD_RS_LO];
                  wr_ok_d = !sh_q[i2cd_pkg::CMD_DIR_BIT];
                end
              end
            end else if (wr_ok_q) begin
              reg_wr_d = 1'b1;
              wdata_d  = sh_q;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rd_xfer_q) begin
              sh_d     = reg_rdata;
              sda_oe_d = !reg_rdata[7];
              st_d     = D_SEND;
            end else begin
              sda_oe_d = 1'b0;
              st_d     = D_RECV;
            end
          end
        end
        D_SEND: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oe_d = 1'b0;
              st_d     = D_RACK;
            end else begin
              sh_d     = {sh_q[6:0], 1'b0};
              sda_oe_d = !sh_q[6];
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            st_d = sda_s_q[1] ? D_IDLE : D_ACK;
          end
        end
        default: st_d = D_IDLE;
      endcase
    end
    if (seq_done && single_cycle_select && !continuous_single_cycle_flag &&
        pds_d == i2cd_pkg::PDS_ACTIVE) begin
      pds_d = i2cd_pkg::PDS_SLEEP;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q                   <= D_IDLE;
      sh_q                   <= 8'h00;
      bit_q                  <= 4'h0;
      byte_q                 <= 2'h0;
      rd_xfer_q              <= 1'b0;
      wr_ok_q                <= 1'b0;
      sda_oe_q               <= 1'b0;
      op_req                 <= 1'b0;
      op_code                <= 2'h0;
      conv_rate              <= 4'h0;
      cal_kind               <= 2'h0;
      register_select        <= 5'h00;
      reg_wr                 <= 1'b0;
      reg_wdata              <= 8'h00;
      powerdown_state_status <= i2cd_pkg::PDS_RESET;
      seen_lo_q              <= 2'h0;
      seen_hi_q              <= 2'h0;
    end else if (clk_en) begin
      st_q                   <= st_d;
      sh_q                   <= sh_d;
      bit_q                  <= bit_d;
      byte_q                 <= byte_d;
      rd_xfer_q              <= rd_xfer_d;
      wr_ok_q                <= wr_ok_d;
      sda_oe_q               <= sda_oe_d;
      op_req                 <= op_req_d;
      op_code                <= op_code_d;
      conv_rate              <= conv_rate_d;
      cal_kind               <= cal_kind_d;
      register_select        <= rs_d;
      reg_wr                 <= reg_wr_d;
      reg_wdata              <= wdata_d;
      powerdown_state_status <= pds_d;
      seen_lo_q              <= seen_lo_d;
      seen_hi_q              <= seen_hi_d;
    end
  end
endmodule

// ---- hdl/i2cd_host.sv ----
`timescale 1ns/1ps
module i2cd_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  i2cd_if.host             bus,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} i2cd_hst_t;

  i2cd_hst_t   st_q, st_d;
  logic [3:0]  qc_q, qc_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bit_q, bit_d;
  logic [8:0]  tx_q, tx_d;
  logic [7:0]  rx_q, rx_d;
  logic [31:0] cmd_q, cmd_d;
  logic        busy_q, busy_d, ackrx_q, ackrx_d;
  logic        scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic [1:0]  sda_s_q;
  logic [31:0] prdata_d;
  logic        pslverr_d, tick, wr_cmd, mapped;

  assign bus.scl_oe_host = scl_oe_q;
  assign bus.sda_oe_host = sda_oe_q;
  assign tick   = qc_q == i2cd_pkg::SCL_QTR_CYC - 4'h1;
  assign wr_cmd = psel && penable && pwrite && pready && paddr == i2cd_pkg::REG_CMD_OFF;
  assign mapped = paddr == i2cd_pkg::REG_CMD_OFF || paddr == i2cd_pkg::REG_STAT_OFF;

  always_comb begin
    st_d      = st_q;
    qc_d      = tick ? 4'h0 : qc_q + 4'h1;
    ph_d      = ph_q;
    bit_d     = bit_q;
    tx_d      = tx_q;
    rx_d      = rx_q;
    cmd_d     = cmd_q;
    busy_d    = busy_q;
    ackrx_d   = ackrx_q;
    scl_oe_d  = scl_oe_q;
    sda_oe_d  = sda_oe_q;
    prdata_d  = prdata;
    pslverr_d = pslverr;
    if (psel && !penable) begin
      pslverr_d = !mapped;
      prdata_d  = 32'h0;
      if (paddr == i2cd_pkg::REG_CMD_OFF) begin
        prdata_d = cmd_q;
      end else if (paddr == i2cd_pkg::REG_STAT_OFF) begin
        prdata_d[i2cd_pkg::STAT_BUSY]                     = busy_q;
        prdata_d[i2cd_pkg::STAT_ACKRX]                    = ackrx_q;
        prdata_d[i2cd_pkg::STAT_RX_LO+7:i2cd_pkg::STAT_RX_LO] = rx_q;
      end
    end
    unique case (st_q)
      H_IDLE: begin
        qc_d = 4'h0;
        ph_d = 2'h0;
        if (wr_cmd && !busy_q) begin
          cmd_d  = pwdata;
          busy_d = 1'b1;
          bit_d  = 4'h0;
          // ack a read byte only when CMDF_ACK is set
          tx_d   = pwdata[i2cd_pkg::CMDF_READ] ?
                   {8'hff, !pwdata[i2cd_pkg::CMDF_ACK]} : {pwdata[7:0], 1'b1};
          st_d   = pwdata[i2cd_pkg::CMDF_START] ? H_START : H_BIT;
        end
      end
      H_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_d = 1'b0;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b1;
            2'h3: begin
              scl_oe_d = 1'b1;
              st_d     = H_BIT;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_d = !tx_q[8];
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              if (bit_q == 4'h8) begin
                ackrx_d = !sda_s_q[1];
              end else begin
                rx_d = {rx_q[6:0], sda_s_q[1]};
              end
            end
            2'h3: begin
              scl_oe_d = 1'b1;
              tx_d     = {tx_q[7:0], 1'b1};
              bit_d    = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                st_d   = cmd_q[i2cd_pkg::CMDF_STOP] ? H_STOP : H_IDLE;
                busy_d = cmd_q[i2cd_pkg::CMDF_STOP];
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            2'h3: begin
              st_d   = H_IDLE;
              busy_d = 1'b0;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= H_IDLE;
      qc_q     <= 4'h0;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      tx_q     <= 9'h1ff;
      rx_q     <= 8'h00;
      cmd_q    <= i2cd_pkg::CMD_RESET;
      busy_q   <= 1'b0;
      ackrx_q  <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_s_q  <= 2'h3;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else if (clk_en) begin
      st_q     <= st_d;
      qc_q     <= qc_d;
      ph_q     <= ph_d;
      bit_q    <= bit_d;
      tx_q     <= tx_d;
      rx_q     <= rx_d;
      cmd_q    <= cmd_d;
      busy_q   <= busy_d;
      ackrx_q  <= ackrx_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      sda_s_q  <= {sda_s_q[0], bus.sda};
      prdata   <= prdata_d;
      pready   <= 1'b1;
      pslverr  <= pslverr_d;
    end
  end

endmodule

// ---- sim/i2cd_chk.sv ----
`timescale 1ns/1ps
module i2cd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       drove_q;
  logic [3:0] low_cnt_q;
  logic [3:0] bit_cnt_q;
  logic       scl_d;
  logic       sda_d;
  logic       drove_d;
  logic [3:0] low_cnt_d;
  logic [3:0] bit_cnt_d;
  logic       start_w;
  logic       stop_w;
  logic [5:0] drv_cnt_q;
  logic [5:0] drv_cnt_d;

  // Bus conditions and bit position since the last start
  always_comb begin
    start_w   = scl && scl_q && sda_q && !sda;
    stop_w    = scl && scl_q && !sda_q && sda;
    scl_d     = scl;
    sda_d     = sda;
    low_cnt_d = scl ? 4'h0 : ((low_cnt_q == 4'hf) ? low_cnt_q : low_cnt_q + 4'h1);
    bit_cnt_d = bit_cnt_q;
    drove_d   = drove_q | sda_oe_dev;
    drv_cnt_d = !sda_oe_dev ? 6'h00 : ((drv_cnt_q == 6'h3f) ? drv_cnt_q : drv_cnt_q + 6'h01);
    if (start_w) begin
      bit_cnt_d = 4'h0;
      drove_d   = 1'b0;
    end else if (scl && !scl_q && bit_cnt_q != 4'hf) begin
      bit_cnt_d = bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      drove_q   <= 1'b0;
      low_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      drv_cnt_q <= 6'h00;
    end else begin
      drv_cnt_q <= drv_cnt_d;
      scl_q     <= scl_d;
      sda_q     <= sda_d;
      drove_q   <= drove_d;
      low_cnt_q <= low_cnt_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  drive_on_low_a: assert property ($rose(sda_oe_dev) |-> !scl && low_cnt_q <= 4'h7)
    else $error("device took the data line outside the low clock phase");
  release_on_low_a: assert property ($fell(sda_oe_dev) |-> !scl && low_cnt_q <= 4'h7)
    else $error("device let go of the data line outside the low clock phase");
  hold_high_a: assert property (scl && scl_q |-> $stable(sda_oe_dev))
    else $error("device changed the data line while the clock was high");
  no_stretch_a: assert property (!scl |-> scl_oe_host)
    else $error("clock line held low by someone other than the host");
  start_quiet_a: assert property (start_w |-> !sda_oe_dev)
    else $error("device driving at a start condition");
  stop_quiet_a: assert property (stop_w |-> !sda_oe_dev && !$past(sda_oe_dev))
    else $error("device driving at a stop condition");
  drive_bounded_a: assert property ($rose(sda_oe_dev) |-> ##[1:250] !sda_oe_dev)
    else $error("device held the data line too long");
  first_ack_a: assert property ($rose(sda_oe_dev) && !drove_q |-> bit_cnt_q == 4'h8)
    else $error("first device drive not after eight address bits");

  start_c: cover property (start_w);
  ack_c:   cover property ($rose(sda_oe_dev) && !drove_q);
  long_c:  cover property (drv_cnt_q == 6'h28);
endmodule

// ---- sim/i2c_command_address_decoder_tb_top.sv ----
`timescale 1ns/1ps
module i2c_command_address_decoder_tb_top;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  sel_hi;
  logic [1:0]  sel_lo;
  logic        strap_hi;
  logic        strap_lo;
  logic [1:0]  pd_target;
  logic [1:0]  cal_set;
  logic        scs;
  logic        cont;
  logic        seq_done;
  logic [7:0]  reg_rdata;
  logic        op_req;
  logic [1:0]  op_code;
  logic [3:0]  conv_rate;
  logic [1:0]  cal_kind;
  logic [4:0]  register_select;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [1:0]  pds;
  int          bad_count;
  int          samples_checked;
  int          op_cnt;
  int          wr_cnt;
  logic [6:0]  dev_a;
  logic [31:0] s;
  logic [1:0]  smap [3] = '{2'h0, 2'h1, 2'h3};

  i2cd_if u_i2cd_if ();
  i2cd_host u_i2cd_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .bus(u_i2cd_if),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  i2cd_dev u_i2cd_dev (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .bus(u_i2cd_if),
    .addr_strap_low(strap_lo), .addr_strap_high(strap_hi), .powerdown_target(pd_target),
    .calibration_kind(cal_set), .single_cycle_select(scs),
    .continuous_single_cycle_flag(cont), .seq_done(seq_done), .reg_rdata(reg_rdata),
    .op_req(op_req), .op_code(op_code), .conv_rate(conv_rate), .cal_kind(cal_kind),
    .register_select(register_select), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .powerdown_state_status(pds));
  i2cd_chk u_i2cd_chk (.pclk(pclk), .presetn(presetn), .scl_oe_host(u_i2cd_if.scl_oe_host),
    .sda_oe_host(u_i2cd_if.sda_oe_host), .sda_oe_dev(u_i2cd_if.sda_oe_dev),
    .scl(u_i2cd_if.scl), .sda(u_i2cd_if.sda));

  // Strap tied to ground, supply or the data line
  assign strap_hi  = (sel_hi == 2'h2) ? u_i2cd_if.sda : sel_hi[0];
  assign strap_lo  = (sel_lo == 2'h2) ? u_i2cd_if.sda : sel_lo[0];
  assign reg_rdata = {3'h5, register_select};

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (op_req === 1'b1) op_cnt++;
    if (reg_wr === 1'b1) wr_cnt++;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One byte on the link, returns the status word once idle
  task automatic xfer(input logic [7:0] b, input logic st, input logic sp, input logic rd,
                      input logic ak, output logic [31:0] r);
    int n;
    apb(i2cd_pkg::REG_CMD_OFF, 1'b1, {20'h0, ak, rd, sp, st, b}, r);
    n = 0;
    do begin
      apb(i2cd_pkg::REG_STAT_OFF, 1'b0, 32'h0, r);
      n++;
    end while (r[i2cd_pkg::STAT_BUSY] !== 1'b0 && n < 2000);
    chk("link idle", 32'h0, 32'(r[i2cd_pkg::STAT_BUSY]));
  endtask

  task automatic t_addr;
    logic [6:0] a;
    for (int i = 0; i < 9; i++) begin
      sel_hi <= 2'(i / 3);
      sel_lo <= 2'(i % 3);
      do_reset();
      a = {3'h3, smap[i / 3], smap[i % 3]};
      xfer({a, 1'b0}, 1'b1, 1'b1, 1'b0, 1'b0, s);
      chk("ack own address", 32'h1, 32'(s[i2cd_pkg::STAT_ACKRX]));
      xfer({a ^ 7'(7'h01 << (i % 7)), 1'b0}, 1'b1, 1'b1, 1'b0, 1'b0, s);
      chk("ack other address", 32'h0, 32'(s[i2cd_pkg::STAT_ACKRX]));
    end
    xfer(8'h00, 1'b1, 1'b1, 1'b0, 1'b0, s);
    chk("ack general call", 32'h0, 32'(s[i2cd_pkg::STAT_ACKRX]));
    $display("test addressing done");
  endtask

  task automatic conv(input logic [1:0] op, input logic [3:0] rate);
    int n0;
    n0 = op_cnt;
    xfer({dev_a, 1'b0}, 1'b1, 1'b0, 1'b0, 1'b0, s);
    xfer({2'b10, op, rate}, 1'b0, 1'b1, 1'b0, 1'b0, s);
    chk("command ack", 32'h1, 32'(s[i2cd_pkg::STAT_ACKRX]));
    chk("op pulses", 32'(op != 2'h0), 32'(op_cnt - n0));
    if (op != 2'h0) begin
      chk("op code", 32'(op), 32'(op_code));
      chk("rate", 32'(rate), 32'(conv_rate));
      chk("cal kind", 32'(cal_set), 32'(cal_kind));
    end
  endtask

  task automatic pulse_done(input logic sc, input logic ct, input logic [1:0] exp);
    scs <= sc;
    cont <= ct;
    @(posedge pclk);
    seq_done <= 1'b1;
    @(posedge pclk);
    seq_done <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("state after done", 32'(exp), 32'(pds));
  endtask

  task automatic t_conv;
    pd_target <= 2'h2;
    cal_set <= 2'h1;
    conv(2'h1, 4'h0);
    chk("standby state", 32'h2, 32'(pds));
    cal_set <= 2'h3;
    conv(2'h2, 4'h7);
    chk("cal state", 32'h0, 32'(pds));
    conv(2'h3, 4'hf);
    conv(2'h0, 4'ha);
    chk("unused op state", 32'h0, 32'(pds));
    pulse_done(1'b1, 1'b1, 2'h0);
    pulse_done(1'b0, 1'b0, 2'h0);
    pulse_done(1'b1, 1'b0, 2'h1);
    conv(2'h3, 4'h5);
    pd_target <= 2'h1;
    conv(2'h1, 4'h5);
    chk("exit to sleep", 32'h1, 32'(pds));
    $display("test conversion commands done");
  endtask

  task automatic t_reg;
    int n0;
    int o0;
    n0 = wr_cnt;
    o0 = op_cnt;
    xfer({dev_a, 1'b0}, 1'b1, 1'b0, 1'b0, 1'b0, s);
    xfer({2'b11, 5'h15, 1'b0}, 1'b0, 1'b0, 1'b0, 1'b0, s);
    xfer(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0, s);
    xfer(8'hc5, 1'b0, 1'b1, 1'b0, 1'b0, s);
    chk("write pulses", 32'h2, 32'(wr_cnt - n0));
    chk("write data", 32'hc5, 32'(reg_wdata));
    chk("write select", 32'h15, 32'(register_select));
    xfer({dev_a, 1'b0}, 1'b1, 1'b0, 1'b0, 1'b0, s);
    xfer(8'h4f, 1'b0, 1'b1, 1'b0, 1'b0, s);
    chk("plain byte ack", 32'h1, 32'(s[i2cd_pkg::STAT_ACKRX]));
    chk("plain byte quiet", 32'h2, 32'(wr_cnt - n0 + op_cnt - o0));
    xfer({dev_a, 1'b0}, 1'b1, 1'b0, 1'b0, 1'b0, s);
    xfer({2'b11, 5'h0a, 1'b1}, 1'b0, 1'b0, 1'b0, 1'b0, s);
    xfer({dev_a, 1'b1}, 1'b1, 1'b0, 1'b0, 1'b0, s);
    chk("read address ack", 32'h1, 32'(s[i2cd_pkg::STAT_ACKRX]));
    xfer(8'h00, 1'b0, 1'b0, 1'b1, 1'b1, s);
    chk("read byte one", 32'haa, 32'(s[15:8]));
    xfer(8'h00, 1'b0, 1'b1, 1'b1, 1'b0, s);
    chk("read byte two", 32'haa, 32'(s[15:8]));
    chk("read no write", 32'h2, 32'(wr_cnt - n0));
    chk("mapped error", 32'h0, 32'(pslverr));
    apb(8'h08, 1'b0, 32'h0, s);
    chk("unmapped error", 32'h1, 32'(pslverr));
    chk("unmapped data", 32'h0, s);
    $display("test register access done");
  endtask

  initial begin
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    sel_hi = 2'h0;
    sel_lo = 2'h0;
    pd_target = 2'h1;
    cal_set = 2'h0;
    scs = 1'b1;
    cont = 1'b0;
    seq_done = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    op_cnt = 0;
    wr_cnt = 0;
    t_addr();
    sel_hi <= 2'h1;
    sel_lo <= 2'h2;
    dev_a = {3'h3, 2'h1, 2'h3};
    do_reset();
    chk("reset state", 32'h1, 32'(pds));
    t_conv();
    t_reg();
    print_verdict();
  end

  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
endmodule
